// ---- include/msrb_pkg.sv ----
// Package for the model-specific register bank: indices, field positions,
// reset values and the packed request/answer carriers.
// Assumes one processor clock; no bus, the execution core drives requests.
package msrb_pkg;
    // Register indices as presented in the index general register
    localparam logic [31:0] IDX_MC_ADDRESS = 32'h0000_0000;
    localparam logic [31:0] IDX_MC_TYPE = 32'h0000_0001;
    localparam logic [31:0] IDX_CACHE_TEST = 32'h0000_000e;
    localparam logic [31:0] IDX_CYCLE_COUNTER = 32'h0000_0010;
    localparam logic [31:0] IDX_FEATURE_ENABLE = 32'hc000_0080;
    localparam logic [31:0] IDX_FAST_CALL = 32'hc000_0081;
    localparam logic [31:0] IDX_WRITE_HANDLING = 32'hc000_0082;
    localparam logic [31:0] IDX_UC_COMBINING = 32'hc000_0085;
    localparam logic [31:0] IDX_STATE_OBSERVE = 32'hc000_0087;
    localparam logic [31:0] IDX_PAGE_FLUSH = 32'hc000_0088;
    localparam logic [31:0] IDX_L2_ARRAY = 32'hc000_0089;

    // Feature enable field positions
    localparam int FE_FAST_CALL_BIT = 0;
    localparam int FE_PREFETCH_BIT = 1;
    localparam int FE_SPEC_ORDER_BIT = 2;
    localparam int FE_GLOBAL_ORDER_BIT = 3;
    localparam int FE_L2_DISABLE_BIT = 4;
    localparam logic [63:0] FE_IMPL_MASK = 64'h0000_0000_0000_001f;
    localparam logic [63:0] FE_RESERVED_MASK = 64'hffff_ffff_ffff_ffe0;

    // Cache test field position (level-1 cache disable)
    localparam int CT_L1_DISABLE_BIT = 3;

    // Fast call target field positions
    localparam int FC_RET_SEL_LSB = 48;
    localparam int FC_CALL_SEL_LSB = 32;

    // Reset values
    localparam logic [63:0] RST_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [63:0] RST_FEATURE_ENABLE = 64'h0000_0000_0000_0002;

    // Request from the execution core
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] index;
        logic [31:0] edx;
        logic [31:0] eax;
    } msrb_req_t;

    // Answer to the execution core
    typedef struct packed {
        logic done;
        logic fault;
        logic [31:0] edx;
        logic [31:0] eax;
    } msrb_rsp_t;

    // Feature controls fanned out to the rest of the processor
    typedef struct packed {
        logic l2_disable;
        logic global_order_disable;
        logic spec_order_disable;
        logic prefetch_enable;
        logic fast_call_enable;
        logic l1_disable;
        logic machine_check_raise;
    } msrb_ctl_t;
endpackage

// ---- rtl/msrb_bank.sv ----
// Model-specific register bank: eleven 64-bit registers reached by
// read and write operations from the execution core.
// Assumes requests arrive as single-cycle strobes from same-clock logic.
//
// Functional notes
// - The index value selects the target register for every read or write.
// - Writes take data from the two data words; reads return into them.
// - Exactly eleven registers are decoded at their fixed indices.
// - Machine-check registers change only by write; reset clears them to zero.
// - The bank never raises a machine-check exception.
// - The cycle counter increments by one on every processor clock without a write to it; a write loads it.
// - Writing one to feature enable bits 63..5 raises protection fault.
// - Feature enable reserved bits always read as zero.
// - Feature enable bit 4 disables the level-2 cache; resets to zero.
// - Feature enable bits 3 and 2 form the write ordering control field.
// - Feature enable bit 1 enables data prefetch; resets to one.
// - Feature enable bit 0 gates the fast call and return instructions.
// - The cache test register provides a level-1 cache disable control.
// - Write handling control clears to zero at reset.
// - Fast call target holds return base, call base and target pointer.
`timescale 1ns/10ps
module msrb_bank (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Request from execution core
    input wire msrb_pkg::msrb_req_t req_in,
    // Answer to execution core
    output msrb_pkg::msrb_rsp_t rsp_out,
    // Feature controls
    output msrb_pkg::msrb_ctl_t ctl_out,
    // Fast call fields
    output logic [15:0] ret_sel_base_out,
    output logic [15:0] call_sel_base_out,
    output logic [31:0] call_target_out
);
    typedef enum logic [10:0] {
        MSRB_SEL_MCA = 11'h001,
        MSRB_SEL_MCT = 11'h002,
        MSRB_SEL_CT = 11'h004,
        MSRB_SEL_CNT = 11'h008,
        MSRB_SEL_FE = 11'h010,
        MSRB_SEL_FC = 11'h020,
        MSRB_SEL_WH = 11'h040,
        MSRB_SEL_UC = 11'h080,
        MSRB_SEL_SO = 11'h100,
        MSRB_SEL_PF = 11'h200,
        MSRB_SEL_L2 = 11'h400
    } msrb_sel_t;

    localparam int NREG = 11;

    logic [10:0] sel;
    logic hit;
    logic [63:0] wdata;
    logic fe_bad;
    logic [NREG-1:0] wr;
    logic [63:0] q [NREG];
    logic [63:0] fe_q;
    logic [63:0] cnt_q;
    logic [63:0] rdata;
    logic fault;

    always_comb begin
        sel = 11'h000;
        unique case (req_in.index)
            msrb_pkg::IDX_MC_ADDRESS: sel = MSRB_SEL_MCA;
            msrb_pkg::IDX_MC_TYPE: sel = MSRB_SEL_MCT;
            msrb_pkg::IDX_CACHE_TEST: sel = MSRB_SEL_CT;
            msrb_pkg::IDX_CYCLE_COUNTER: sel = MSRB_SEL_CNT;
            msrb_pkg::IDX_FEATURE_ENABLE: sel = MSRB_SEL_FE;
            msrb_pkg::IDX_FAST_CALL: sel = MSRB_SEL_FC;
            msrb_pkg::IDX_WRITE_HANDLING: sel = MSRB_SEL_WH;
            msrb_pkg::IDX_UC_COMBINING: sel = MSRB_SEL_UC;
            msrb_pkg::IDX_STATE_OBSERVE: sel = MSRB_SEL_SO;
            msrb_pkg::IDX_PAGE_FLUSH: sel = MSRB_SEL_PF;
            msrb_pkg::IDX_L2_ARRAY: sel = MSRB_SEL_L2;
            default: sel = 11'h000;
        endcase
    end
    assign hit = |sel;

    assign wdata = {req_in.edx, req_in.eax};

    assign fe_bad = sel[4] && req_in.write && |(wdata & msrb_pkg::FE_RESERVED_MASK);

    assign fault = req_in.valid && (!hit || fe_bad);

    // Write strobes, suppressed on any fault
    assign wr = (req_in.valid && req_in.write && !fault) ? sel : 11'h000;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_regs
            if (g != 3 && g != 4) begin : g_plain
                msrb_reg64 #(
                    .RESET_VALUE(msrb_pkg::RST_ZERO)
                ) u_reg (
                    .clk_in(clk_in),
                    .rst_b_in(rst_b_in),
                    .wr_in(wr[g]),
                    .data_in(wdata),
                    .q_out(q[g])
                );
            end else begin : g_special
                assign q[g] = (g == 3) ? cnt_q : fe_q;
            end
        end
    endgenerate

    msrb_counter64 u_counter (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .load_in(wr[3]),
        .data_in(wdata),
        .count_out(cnt_q)
    );

    msrb_reg64 #(
        .RESET_VALUE(msrb_pkg::RST_FEATURE_ENABLE)
    ) u_feature (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wr_in(wr[4]),
        .data_in(wdata & msrb_pkg::FE_IMPL_MASK),
        .q_out(fe_q)
    );

    // Read multiplexer
    always_comb begin
        rdata = 64'h0000_0000_0000_0000;
        for (int i = 0; i < NREG; i++) begin
            if (sel[i]) begin
                rdata = q[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rsp_out <= '0;
        end else begin
            rsp_out.done <= req_in.valid;
            rsp_out.fault <= fault;
            if (req_in.valid && !req_in.write && hit) begin
                rsp_out.edx <= rdata[63:32];
                rsp_out.eax <= rdata[31:0];
            end
        end
    end

    // Control outputs
    // feature enable, cache test and fast call fields, registered
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_out <= '0;
            ret_sel_base_out <= 16'h0000;
            call_sel_base_out <= 16'h0000;
            call_target_out <= 32'h0000_0000;
        end else begin
            ctl_out.l2_disable <= fe_q[msrb_pkg::FE_L2_DISABLE_BIT];
            ctl_out.global_order_disable <= fe_q[msrb_pkg::FE_GLOBAL_ORDER_BIT];
            ctl_out.spec_order_disable <= fe_q[msrb_pkg::FE_SPEC_ORDER_BIT];
            ctl_out.prefetch_enable <= fe_q[msrb_pkg::FE_PREFETCH_BIT];
            ctl_out.fast_call_enable <= fe_q[msrb_pkg::FE_FAST_CALL_BIT];
            ctl_out.l1_disable <= q[2][msrb_pkg::CT_L1_DISABLE_BIT];
            ctl_out.machine_check_raise <= 1'b0;
            ret_sel_base_out <= q[5][msrb_pkg::FC_RET_SEL_LSB +: 16];
            call_sel_base_out <= q[5][msrb_pkg::FC_CALL_SEL_LSB +: 16];
            call_target_out <= q[5][31:0];
        end
    end
endmodule

// ---- rtl/msrb_counter64.sv ----
// Free-running 64-bit cycle counter that software may load.
// Assumes the load strobe comes from logic on the same clock.
`timescale 1ns/10ps
module msrb_counter64 (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Load port
    input wire logic load_in,
    input wire logic [63:0] data_in,
    // Count value
    output logic [63:0] count_out
);
    // Count every clock, load overrides
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_out <= 64'h0000_0000_0000_0000;
        end else if (load_in) begin
            count_out <= data_in;
        end else begin
            count_out <= count_out + 64'h0000_0000_0000_0001;
        end
    end
endmodule

// ---- rtl/msrb_reg64.sv ----
// One 64-bit writable register with a reset value.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/10ps
module msrb_reg64 #(
    parameter logic [63:0] RESET_VALUE = 64'h0000_0000_0000_0000
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Write port
    input wire logic wr_in,
    input wire logic [63:0] data_in,
    // Stored value
    output logic [63:0] q_out
);
    // Holding register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q_out <= RESET_VALUE;
        end else if (wr_in) begin
            q_out <= data_in;
        end
    end
endmodule

// ---- testbench/msrb_bank_props.sv ----
// Checker for the register bank ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
module msrb_bank_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Watched ports
    input wire msrb_pkg::msrb_req_t req_in,
    input wire msrb_pkg::msrb_rsp_t rsp_out,
    input wire msrb_pkg::msrb_ctl_t ctl_out,
    input wire logic [15:0] ret_sel_base_out,
    input wire logic [15:0] call_sel_base_out,
    input wire logic [31:0] call_target_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // Decoded request kinds
    wire logic mapped = req_in.index inside {32'h0, 32'h1, 32'he, 32'h10, 32'hc000_0080,
        32'hc000_0081, 32'hc000_0082, 32'hc000_0085, [32'hc000_0087:32'hc000_0089]};
    wire logic wr = req_in.valid & req_in.write;
    wire logic fe_hit = req_in.index == msrb_pkg::IDX_FEATURE_ENABLE;
    wire logic fe_bad = |({req_in.edx, req_in.eax} & msrb_pkg::FE_RESERVED_MASK);

    a_done_one_cycle: assert property (req_in.valid |=> rsp_out.done)
        else $error("done missing after request");
    a_done_has_cause: assert property (rsp_out.done |-> $past(req_in.valid))
        else $error("done without request");
    a_no_mc_raise: assert property (!ctl_out.machine_check_raise)
        else $error("machine check raised");
    a_unmapped_faults: assert property (req_in.valid && !mapped |=> rsp_out.fault)
        else $error("unmapped index without fault");
    a_mapped_no_fault: assert property (req_in.valid && mapped && !(wr && fe_hit && fe_bad)
        |=> !rsp_out.fault)
        else $error("mapped index faulted");
    a_reserved_faults: assert property (wr && fe_hit && fe_bad
        |=> rsp_out.fault ##1 $stable(ctl_out))
        else $error("reserved write accepted");
    a_fe_ctl_follows: assert property (wr && fe_hit && !fe_bad
        |-> ##2 ctl_out[6:2] == $past(req_in.eax[4:0], 2))
        else $error("feature controls wrong");
    a_fe_reads_zero: assert property (req_in.valid && !req_in.write && fe_hit
        |=> rsp_out.edx == 32'h0 && rsp_out.eax[31:5] == 27'h0)
        else $error("reserved bits read nonzero");
    a_fast_call_split: assert property (wr && req_in.index == msrb_pkg::IDX_FAST_CALL
        |-> ##2 {ret_sel_base_out, call_sel_base_out, call_target_out}
        == $past({req_in.edx, req_in.eax}, 2))
        else $error("fast call fields wrong");
    a_l1_follows: assert property (wr && req_in.index == msrb_pkg::IDX_CACHE_TEST
        |-> ##2 ctl_out.l1_disable == $past(req_in.eax[3], 2))
        else $error("level-1 disable wrong");
    // Main scenarios
    c_fe_write: cover property (wr && fe_hit && !fe_bad);
    c_fault: cover property (rsp_out.fault);
    c_unmapped: cover property (req_in.valid && !mapped);
endmodule

// ---- testbench/msrb_core_model.sv ----
// Execution core model issuing bank reads and writes.
// Assumes the answer comes exactly one clock after the taking edge.
`timescale 1ns/10ps
module msrb_core_model (
    // Clock
    input wire logic clk_in,
    // Request and answer
    output msrb_pkg::msrb_req_t req_out,
    input wire msrb_pkg::msrb_rsp_t rsp_in
);
    initial req_out = '0;
    // One transfer; released lines show inverted values
    task automatic op(input logic wr, input logic [31:0] idx, input logic [63:0] d,
            output logic [63:0] q, output logic f);
        @(posedge clk_in);
        req_out <= {1'b1, wr, idx, d};
        @(posedge clk_in);
        req_out <= {1'b0, wr, ~idx, ~d};
        // Answer stands until this edge; take it as it is sampled
        @(posedge clk_in);
        q = {rsp_in.edx, rsp_in.eax};
        f = rsp_in.done ? rsp_in.fault : 1'bx;
    endtask
endmodule

// ---- testbench/tb.sv ----
// Top testbench for the register bank.
// Assumes the core model drives requests; the checker is bound below.
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    msrb_pkg::msrb_req_t req;
    msrb_pkg::msrb_rsp_t rsp;
    msrb_pkg::msrb_ctl_t ctl;
    logic [15:0] ret_sel;
    logic [15:0] call_sel;
    logic [31:0] target;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [63:0] q;
    logic f;
    logic [31:0] rw_idx [9] = '{32'h0, 32'h1, 32'he, 32'hc000_0081, 32'hc000_0082,
        32'hc000_0085, 32'hc000_0087, 32'hc000_0088, 32'hc000_0089};
    msrb_bank DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(req), .rsp_out(rsp),
        .ctl_out(ctl), .ret_sel_base_out(ret_sel), .call_sel_base_out(call_sel),
        .call_target_out(target));
    msrb_core_model core (.clk_in(clk_in), .req_out(req), .rsp_in(rsp));
    // Clock and cycle ceiling
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end
    // Compare fault flag and data together
    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [31:0] idx, input logic [63:0] exp);
        core.op(1'b0, idx, 64'h0, q, f);
        chk({f, q}, {1'b0, exp});
    endtask
    task automatic wr(input logic [31:0] idx, input logic [63:0] d, input logic fe);
        core.op(1'b1, idx, d, q, f);
        chk({64'h0, f}, {64'h0, fe});
    endtask
    task automatic t_reset();
        rd(msrb_pkg::IDX_FEATURE_ENABLE, 64'h2);
        rd(msrb_pkg::IDX_MC_ADDRESS, 64'h0);
        rd(msrb_pkg::IDX_WRITE_HANDLING, 64'h0);
        $display("test reset values done");
    endtask
    task automatic t_rw();
        for (int i = 0; i < 9; i++) wr(rw_idx[i], {~rw_idx[i], rw_idx[i]}, 1'b0);
        @(posedge clk_in);
        chk({ret_sel, call_sel, target}, {1'b0, 32'h3fff_ff7e, 32'hc000_0081});
        chk(ctl.l1_disable, 65'h1);
        for (int i = 0; i < 9; i++) rd(rw_idx[i], {~rw_idx[i], rw_idx[i]});
        $display("test register read back done");
    endtask
    task automatic t_fe();
        wr(msrb_pkg::IDX_FEATURE_ENABLE, 64'h1f, 1'b0);
        @(posedge clk_in);
        chk(ctl[6:2], 65'h1f);
        chk(ctl.machine_check_raise, 65'h0);
        wr(msrb_pkg::IDX_FEATURE_ENABLE, 64'h1_0000_0000, 1'b1);
        wr(msrb_pkg::IDX_FEATURE_ENABLE, 64'h20, 1'b1);
        rd(msrb_pkg::IDX_FEATURE_ENABLE, 64'h1f);
        wr(msrb_pkg::IDX_FEATURE_ENABLE, 64'ha, 1'b0);
        rd(msrb_pkg::IDX_FEATURE_ENABLE, 64'ha);
        $display("test feature enable done");
    endtask
    task automatic t_counter();
        // Taking edges are three clocks apart: load, +2 at first read, +5 at second
        wr(msrb_pkg::IDX_CYCLE_COUNTER, 64'hffff_ffff_ffff_fffd, 1'b0);
        rd(msrb_pkg::IDX_CYCLE_COUNTER, 64'hffff_ffff_ffff_ffff);
        rd(msrb_pkg::IDX_CYCLE_COUNTER, 64'h2);
        $display("test cycle counter done");
    endtask
    task automatic t_unmapped();
        wr(32'h2, 64'h0, 1'b1);
        wr(32'hc000_0083, 64'h0, 1'b1);
        // Refused read keeps the last answered data
        core.op(1'b0, 32'hc000_0086, 64'h0, q, f);
        chk({f, q}, {1'b1, 64'h2});
        rd(msrb_pkg::IDX_MC_ADDRESS, 64'hffff_ffff_0000_0000);
        $display("test unmapped index done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_rw();
        t_fe();
        t_counter();
        t_unmapped();
        final_report();
    end
endmodule

bind msrb_bank msrb_bank_props props (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .req_in(req_in), .rsp_out(rsp_out), .ctl_out(ctl_out),
    .ret_sel_base_out(ret_sel_base_out), .call_sel_base_out(call_sel_base_out),
    .call_target_out(call_target_out));
